// >>> bench/io_element_periphery_ctrl_tb_top.sv
// self-checking bench for the io periphery block
`timescale 1ns/100ps
`default_nettype none
module io_element_periphery_ctrl_tb_top;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [9:0]  address = '0;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = '0;
   logic [3:0]  byteenable = '0;
   logic [31:0] readdata, rd;
   logic        waitrequest;
   logic [19:0] pin_in, pin_out, pin_oe;
   logic [19:0] ext_val = '0;
   logic [19:0] ext_en = '0;
   logic [3:0]  dedicated_in = '0;
   logic [26:0] row_chan_in = '0;
   logic [15:0] col_chan_in = '0;
   logic [26:0] le_first_chan = '0;
   logic [15:0] row_drive_a, row_drive_b;
   logic [3:0]  col_drive_a, col_drive_b, dedicated_to_core;
   logic [2:0]  rows [12] = '{3'h4, 3'h1, 3'h5, 3'h2, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5};
   int          bad_count = 0;
   int          num_checks = 0;
   int          cycles = 0;

   always #25 clk = ~clk;

   io_element_periphery_ctrl dut (.clk, .arst_n, .address, .read, .write, .writedata, .byteenable,
      .readdata, .waitrequest, .pin_in, .pin_out, .pin_oe, .dedicated_in, .row_chan_in,
      .col_chan_in, .le_first_chan, .row_drive_a, .row_drive_b, .col_drive_a, .col_drive_b,
      .dedicated_to_core);
   pin_side_model #(.N(20)) u_pins (.pin_out, .pin_oe, .ext_val, .ext_en, .clk, .pin_in);

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic ck1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic bus_wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clk);
      address <= a;
      writedata <= d;
      byteenable <= be;
      write <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask

   task automatic bus_rd(input logic [9:0] a, output logic [31:0] d);
      @(posedge clk);
      address <= a;
      read <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      d = readdata;
      read <= 1'b0;
   endtask

   // f: clear enable, drive b, drive a, invert, register used, register on output
   function automatic logic [31:0] cw(input logic [1:0] m, input logic [4:0] os,
      input logic [3:0] ck, input logic [3:0] cl, input logic [3:0] oe, input logic [5:0] f);
      return {7'h0, f[5:3], oe, cl, ck, os, f[2:0], m};
   endfunction

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         test_done();
      end
   end

   initial begin
      step(16);
      arst_n <= 1'b1;
      bus_rd(10'h00c, rd); chk(rd, 32'h0);
      bus_rd(10'h104, rd); chk(rd, 32'h0);
      bus_rd(10'h140, rd); chk(rd, 32'h0);
      for (int k = 0; k < 12; k++) begin
         bus_rd(10'h180 + 10'(4 * k), rd); chk(rd, {29'h0, rows[k]});
      end
      bus_wr(10'h00c, 32'hffffffff, 4'hf);
      bus_rd(10'h00c, rd); chk(rd, 32'h01ffffff);
      bus_wr(10'h00c, 32'h0, 4'h1);
      bus_rd(10'h00c, rd); chk(rd, 32'h01ffff00);
      step(4); ck1(pin_oe[3], 1'b0);
      bus_wr(10'h3fc, 32'hffffffff, 4'hf);
      bus_rd(10'h3fc, rd); chk(rd, 32'h0);
      // row output picks the last channel, then inverted
      bus_wr(10'h000, cw(2'h1, 5'd26, 4'h0, 4'h0, 4'hf, 6'h0), 4'hf);
      row_chan_in <= 27'h4000000;
      step(4); ck1(pin_out[0], 1'b1);
      ck1(pin_oe[0], 1'b1);
      bus_wr(10'h000, cw(2'h1, 5'd26, 4'h0, 4'h0, 4'hf, 6'h4), 4'hf);
      step(4); ck1(pin_out[0], 1'b0);
      // enable lines 4 to 11 each sourced from dedicated input 3
      for (int k = 4; k < 12; k++) begin
         bus_wr(10'h100 + 10'(4 * k), 32'h23, 4'h1);
         bus_wr(10'h000, cw(2'h2, 5'd26, 4'h0, 4'h0, 4'(k), 6'h0), 4'hf);
         dedicated_in <= 4'h8; step(10); ck1(pin_oe[0], 1'b1);
         dedicated_in <= 4'h0; step(10); ck1(pin_oe[0], 1'b0);
      end
      // shared lines as enables from a logic element channel
      for (int j = 0; j < 2; j++) begin
         bus_wr(10'h104 + 10'(8 * j), 32'h3, 4'h1);
         bus_wr(10'h140, 32'(1 << j), 4'h1);
         bus_wr(10'h000, cw(2'h1, 5'd26, 4'h0, 4'h0, 4'(1 + 2 * j), 6'h0), 4'hf);
         le_first_chan <= 27'h8; step(6); ck1(pin_oe[0], 1'b1);
         le_first_chan <= 27'h0; step(6); ck1(pin_oe[0], 1'b0);
      end
      // column output picks channel 6 of sixteen
      bus_wr(10'h040, cw(2'h1, 5'd3, 4'h0, 4'h0, 4'hf, 6'h0), 4'hf);
      col_chan_in <= 16'h0040; step(4); ck1(pin_out[16], 1'b1);
      col_chan_in <= 16'hffbf; step(4); ck1(pin_out[16], 1'b0);
      // input cells onto row and column channels
      bus_wr(10'h008, cw(2'h0, 5'd0, 4'h0, 4'h0, 4'hf, 6'h18), 4'hf);
      bus_wr(10'h044, cw(2'h0, 5'd0, 4'h0, 4'h0, 4'h0, 6'h08), 4'hf);
      bus_wr(10'h03c, cw(2'h0, 5'd0, 4'h0, 4'h0, 4'h0, 6'h08), 4'hf);
      ext_en <= 20'h28004;
      ext_val <= 20'h28004;
      step(8); ck1(row_drive_a[2], 1'b1);
      ck1(row_drive_a[15], 1'b1);
      ck1(row_drive_b[2], 1'b1);
      ck1(col_drive_a[1], 1'b1);
      ck1(col_drive_b[1], 1'b0);
      ck1(pin_oe[2], 1'b0);
      bus_rd(10'h148, rd); chk(rd & 32'h20004, 32'h20004);
      ext_val <= 20'h0;
      step(8); ck1(row_drive_a[2], 1'b0);
      ck1(row_drive_a[15], 1'b0);
      // output register clocked by line 0, cleared by line 2
      bus_wr(10'h100, 32'h21, 4'h1);
      bus_wr(10'h108, 32'h22, 4'h1);
      bus_wr(10'h000, cw(2'h1, 5'd26, 4'h0, 4'h2, 4'hf, 6'h23), 4'hf);
      step(12); ck1(pin_out[0], 1'b0);
      dedicated_in <= 4'h2; step(12); ck1(pin_out[0], 1'b1);
      row_chan_in <= 27'h0; step(12); ck1(pin_out[0], 1'b1);
      dedicated_in <= 4'h6; step(12); ck1(pin_out[0], 1'b0);
      chk({28'h0, dedicated_to_core}, 32'h6);
      bus_rd(10'h144, rd); chk(rd, 32'h5);
      // input register on cell 2, clocked by line 0
      bus_wr(10'h008, cw(2'h0, 5'd0, 4'h0, 4'h0, 4'hf, 6'h0a), 4'hf);
      ext_val <= 20'h00004;
      step(8); ck1(row_drive_a[2], 1'b0);
      dedicated_in <= 4'h4; step(8); ck1(row_drive_a[2], 1'b0);
      dedicated_in <= 4'h6; step(10); ck1(row_drive_a[2], 1'b1);
      test_done();
   end
endmodule
`default_nettype wire

// >>> bench/io_periph_asserts.sv
// port-level checks for the io periphery block
`timescale 1ns/100ps
`default_nettype none
module io_periph_asserts #(
   parameter int ROW_CELLS = 16,
   parameter int COL_CELLS = 4
) (
   input wire logic                             clk,
   input wire logic                             arst_n,
   input wire logic [9:0]                       address,
   input wire logic                             read,
   input wire logic                             write,
   input wire logic [31:0]                      readdata,
   input wire logic                             waitrequest,
   input wire logic [ROW_CELLS+COL_CELLS-1:0]   pin_oe,
   input wire logic [3:0]                       dedicated_in,
   input wire logic [3:0]                       dedicated_to_core
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered next cycle");
   a_wait_single: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_wait_cause: assert property (!waitrequest |-> $past(read || write))
      else $error("waitrequest low without a request");
   a_read_hold: assert property ($changed(readdata) |-> !waitrequest)
      else $error("readdata changed outside an answer");
   a_write_keep: assert property (write && waitrequest |=> $stable(readdata))
      else $error("write disturbed readdata");
   a_unmapped_zero: assert property (read && waitrequest && address == 10'h3fc |=> readdata == 32'h0)
      else $error("unmapped read not zero");
   a_reset_idle: assert property ($rose(arst_n) |-> waitrequest && pin_oe == '0)
      else $error("outputs not idle after reset");
   a_dedic_follow: assert property ($stable(dedicated_in) [*8] |-> dedicated_to_core == dedicated_in)
      else $error("dedicated input not passed to core");

   cover property (read && !waitrequest);
   cover property (write && !waitrequest);
   cover property ($rose(pin_oe[0]));
endmodule

bind io_element_periphery_ctrl io_periph_asserts #(.ROW_CELLS(ROW_CELLS), .COL_CELLS(COL_CELLS))
   u_chk (.clk, .arst_n, .address, .read, .write, .readdata, .waitrequest, .pin_oe,
          .dedicated_in, .dedicated_to_core);
`default_nettype wire

// >>> bench/pin_side_model.sv
// board side of the io pins: resolves each pin from both drivers
`timescale 1ns/100ps
`default_nettype none
module pin_side_model #(
   parameter int N = 20
) (
   input wire logic [N-1:0]  pin_out,
   input wire logic [N-1:0]  pin_oe,
   input wire logic [N-1:0]  ext_val,
   input wire logic [N-1:0]  ext_en,
   input wire logic          clk,
   output var logic [N-1:0]  pin_in
);
   logic [N-1:0] float_val = '0;
   // an undriven pin wanders instead of keeping its last level
   always @(posedge clk) float_val <= ~float_val;
   always_comb
      for (int i = 0; i < N; i++)
         pin_in[i] = (pin_oe[i] && ext_en[i]) ? 1'bx :
                     pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : float_val[i];
endmodule
`default_nettype wire

// >>> core/io_element_periphery_ctrl.sv
// io cell array with peripheral control bus and register slave
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "io_periph_cfg.svh"

module io_element_periphery_ctrl #(
   parameter int NUM_COLS  = 27,
   parameter int VARIANT   = 5,
   parameter int ROW_CELLS = 16,
   parameter int COL_CELLS = 4
) (
   // clock and reset
   input  wire logic                                    clk,
   input  wire logic                                    arst_n,
   // avalon-mm slave
   input  wire logic [9:0]                              address,
   input  wire logic                                    read,
   input  wire logic                                    write,
   input  wire logic [31:0]                             writedata,
   input  wire logic [3:0]                              byteenable,
   output var  logic [31:0]                             readdata,
   output var  logic                                    waitrequest,
   // device pins
   input  wire logic [ROW_CELLS+COL_CELLS-1:0]          pin_in,
   output var  logic [ROW_CELLS+COL_CELLS-1:0]          pin_out,
   output var  logic [ROW_CELLS+COL_CELLS-1:0]          pin_oe,
   input  wire logic [3:0]                              dedicated_in,
   // core routing
   input  wire logic [NUM_COLS-1:0]                     row_chan_in,
   input  wire logic [15:0]                             col_chan_in,
   input  wire logic [NUM_COLS-1:0]                     le_first_chan,
   output var  logic [ROW_CELLS-1:0]                    row_drive_a,
   output var  logic [ROW_CELLS-1:0]                    row_drive_b,
   output var  logic [COL_CELLS-1:0]                    col_drive_a,
   output var  logic [COL_CELLS-1:0]                    col_drive_b,
   output var  logic [3:0]                              dedicated_to_core
);
   localparam int NCELLS  = ROW_CELLS + COL_CELLS;
   localparam int NLINES  = 12;
   localparam logic LARGEST = (VARIANT == 5);

   logic [31:0]       cell_cfg [NCELLS];
   logic [5:0]        src_cfg [NLINES];
   logic [1:0]        role;
   logic [3:0]        ded_s1, ded_s2, ded_s3;
   logic [NCELLS-1:0] pin_s1, pin_s2, pin_s3, pin_val;
   logic [NLINES-1:0] bus_line, bus_prev;
   logic [NCELLS-1:0] cell_reg;
   logic [NCELLS-1:0] core_data, clk_en, clr_act, oe_act, in_val;
   logic [NLINES-1:0] next_bus;
   logic [31:0]       next_readdata;
   logic              acc_write;

   // line usable by a cell for the given role
   function automatic logic pick(input logic [3:0] sel,
                                 input io_periph_pkg::ctrl_kind_t kind,
                                 input logic [NLINES-1:0] lines,
                                 input logic [1:0] shared_role);
      logic ok;
      ok = 1'b0;
      case (sel)
         4'h0: ok = (kind == io_periph_pkg::KIND_CLOCK);
         4'h1: ok = shared_role[0] ? (kind == io_periph_pkg::KIND_ENABLE)
                                   : (kind == io_periph_pkg::KIND_CLOCK);
         4'h2: ok = (kind == io_periph_pkg::KIND_CLEAR);
         4'h3: ok = shared_role[1] ? (kind == io_periph_pkg::KIND_ENABLE)
                                   : (kind == io_periph_pkg::KIND_CLEAR);
         default: ok = (kind == io_periph_pkg::KIND_ENABLE) && (sel < 4'hc)
                       && (LARGEST || sel < 4'h6);
      endcase
      pick = ok ? lines[sel] : 1'b0;
   endfunction

   // register hit test in a bank of words
   function automatic logic hit(input logic [9:0] addr, input logic [9:0] base,
                                input int count);
      hit = (addr >= base) && (int'(addr - base) < 4 * count);
   endfunction

   function automatic int word_of(input logic [9:0] addr, input logic [9:0] base);
      word_of = int'((addr - base) >> 2);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      merge = res;
   endfunction

   // source row of each line in this variant
   function automatic logic [2:0] row_of(input int line);
      logic [17:0] map;
      map = 18'h3ffff;
      case (line)
         0: map = `IOP_ROWMAP_0;
         1: map = `IOP_ROWMAP_1;
         2: map = `IOP_ROWMAP_2;
         3: map = `IOP_ROWMAP_3;
         4: map = `IOP_ROWMAP_4;
         5: map = `IOP_ROWMAP_5;
         6: map = `IOP_ROWMAP_6;
         7: map = `IOP_ROWMAP_7;
         8: map = `IOP_ROWMAP_8;
         9: map = `IOP_ROWMAP_9;
         10: map = `IOP_ROWMAP_10;
         11: map = `IOP_ROWMAP_11;
         default: map = 18'h3ffff;
      endcase
      row_of = map[3*VARIANT +: 3];
   endfunction

   assign acc_write = write && !waitrequest;

   // bus slave handshake: one wait cycle per access
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         waitrequest <= 1'b1;
         readdata    <= 32'h00000000;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
         if (read && waitrequest) begin
            readdata <= next_readdata;
         end
      end
   end

   always_comb begin
      next_readdata = 32'h00000000;
      if (hit(address, `IOP_CELL_BASE, NCELLS)) begin
         next_readdata = cell_cfg[word_of(address, `IOP_CELL_BASE)];
      end else if (hit(address, `IOP_SRC_BASE, NLINES)) begin
         next_readdata = {26'h0000000, src_cfg[word_of(address, `IOP_SRC_BASE)]};
      end else if (address == `IOP_ROLE_ADDR) begin
         next_readdata = {30'h00000000, role};
      end else if (address == `IOP_BUS_ADDR) begin
         next_readdata = {20'h00000, bus_line};
      end else if (address == `IOP_PIN_ADDR) begin
         next_readdata = 32'(pin_val);
      end else if (hit(address, `IOP_ROWMAP_BASE, NLINES)) begin
         next_readdata = {29'h00000000, row_of(word_of(address, `IOP_ROWMAP_BASE))};
      end
   end

   // configuration registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NCELLS; i++) begin
            cell_cfg[i] <= `IOP_CELL_RST;
         end
         for (int k = 0; k < NLINES; k++) begin
            src_cfg[k] <= `IOP_SRC_RST;
         end
         role <= `IOP_ROLE_RST;
      end else if (acc_write) begin
         if (hit(address, `IOP_CELL_BASE, NCELLS)) begin
            cell_cfg[word_of(address, `IOP_CELL_BASE)] <=
               merge(cell_cfg[word_of(address, `IOP_CELL_BASE)], writedata, byteenable)
               & `IOP_CELL_MASK;
         end else if (hit(address, `IOP_SRC_BASE, NLINES) && byteenable[0]) begin
            src_cfg[word_of(address, `IOP_SRC_BASE)] <= writedata[5:0];
         end else if (address == `IOP_ROLE_ADDR && byteenable[0]) begin
            role <= writedata[1:0];
         end
      end
   end

   // pin and dedicated input synchronisers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ded_s1            <= 4'h0;
         ded_s2            <= 4'h0;
         ded_s3            <= 4'h0;
         dedicated_to_core <= 4'h0;
         pin_s1            <= '0;
         pin_s2            <= '0;
         pin_s3            <= '0;
         pin_val           <= '0;
      end else begin
         ded_s1 <= dedicated_in;
         ded_s2 <= ded_s1;
         ded_s3 <= ded_s2;
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         for (int b = 0; b < 4; b++) begin
            if (ded_s2[b] == ded_s3[b]) begin
               dedicated_to_core[b] <= ded_s3[b];
            end
         end
         for (int i = 0; i < NCELLS; i++) begin
            if (pin_s2[i] == pin_s3[i]) begin
               pin_val[i] <= pin_s3[i];
            end
         end
      end
   end

   // peripheral bus line sources
   always_comb begin
      next_bus = '0;
      for (int k = 0; k < NLINES; k++) begin
         if (k < 6 || LARGEST) begin
            if (src_cfg[k][`IOP_F_SRC_DED]) begin
               next_bus[k] = dedicated_to_core[src_cfg[k][1:0]];
            end else if (int'(src_cfg[k][`IOP_F_SRC_IDX]) < NUM_COLS) begin
               next_bus[k] = le_first_chan[src_cfg[k][`IOP_F_SRC_IDX]];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_line <= '0;
         bus_prev <= '0;
      end else begin
         bus_line <= next_bus;
         bus_prev <= bus_line;
      end
   end

   // per cell control and data selection
   always_comb begin
      logic [4:0] osel;
      osel = 5'h00;
      for (int i = 0; i < NCELLS; i++) begin
         osel = cell_cfg[i][`IOP_F_OUT_SEL];
         if (i < ROW_CELLS) begin
            core_data[i] = (int'(osel) < NUM_COLS) ? row_chan_in[osel] : 1'b0;
         end else begin
            core_data[i] = col_chan_in[{osel[2:0], 1'(i)}];
         end
         core_data[i] = core_data[i] ^ cell_cfg[i][`IOP_F_INVERT];
         clk_en[i] = pick(cell_cfg[i][`IOP_F_CLK_SEL], io_periph_pkg::KIND_CLOCK,
                          bus_line, role)
                     && !pick(cell_cfg[i][`IOP_F_CLK_SEL], io_periph_pkg::KIND_CLOCK,
                              bus_prev, role);
         clr_act[i] = cell_cfg[i][`IOP_F_CLR_EN]
                      && pick(cell_cfg[i][`IOP_F_CLR_SEL], io_periph_pkg::KIND_CLEAR,
                              bus_line, role);
         oe_act[i] = (cell_cfg[i][`IOP_F_OE_SEL] == `IOP_OE_ALWAYS)
                     || pick(cell_cfg[i][`IOP_F_OE_SEL], io_periph_pkg::KIND_ENABLE,
                             bus_line, role);
         in_val[i] = (cell_cfg[i][`IOP_F_REG_EN] && !cell_cfg[i][`IOP_F_REG_OUT])
                     ? cell_reg[i] : pin_val[i];
      end
   end

   // cell register, pin drivers and routing drivers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cell_reg <= '0;
      end else begin
         for (int i = 0; i < NCELLS; i++) begin
            if (clr_act[i]) begin
               cell_reg[i] <= 1'b0;
            end else if (clk_en[i]) begin
               cell_reg[i] <= cell_cfg[i][`IOP_F_REG_OUT] ? core_data[i] : pin_val[i];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_out <= '0;
         pin_oe  <= '0;
      end else begin
         for (int i = 0; i < NCELLS; i++) begin
            pin_out[i] <= (cell_cfg[i][`IOP_F_REG_EN] && cell_cfg[i][`IOP_F_REG_OUT])
                          ? cell_reg[i] : core_data[i];
            case (io_periph_pkg::pin_mode_t'(cell_cfg[i][`IOP_F_MODE]))
               io_periph_pkg::MODE_OUTPUT,
               io_periph_pkg::MODE_BIDIR: pin_oe[i] <= oe_act[i];
               default: pin_oe[i] <= 1'b0;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         row_drive_a <= '0;
         row_drive_b <= '0;
         col_drive_a <= '0;
         col_drive_b <= '0;
      end else begin
         for (int i = 0; i < ROW_CELLS; i++) begin
            row_drive_a[i] <= in_val[i] && cell_cfg[i][`IOP_F_DRIVE_A]
                              && cell_cfg[i][`IOP_F_MODE] != 2'h1;
            row_drive_b[i] <= in_val[i] && cell_cfg[i][`IOP_F_DRIVE_B]
                              && cell_cfg[i][`IOP_F_MODE] != 2'h1;
         end
         for (int c = 0; c < COL_CELLS; c++) begin
            col_drive_a[c] <= in_val[ROW_CELLS+c] && cell_cfg[ROW_CELLS+c][`IOP_F_DRIVE_A]
                              && cell_cfg[ROW_CELLS+c][`IOP_F_MODE] != 2'h1;
            col_drive_b[c] <= in_val[ROW_CELLS+c] && cell_cfg[ROW_CELLS+c][`IOP_F_DRIVE_B]
                              && cell_cfg[ROW_CELLS+c][`IOP_F_MODE] != 2'h1;
         end
      end
   end

endmodule
`default_nettype wire

// >>> core/io_periph_cfg.svh
// register offsets, field positions, reset values and row tables of the io periphery
`ifndef IO_PERIPH_CFG_SVH
`define IO_PERIPH_CFG_SVH

// byte offsets on the register bus
`define IOP_CELL_BASE   10'h000
`define IOP_SRC_BASE    10'h100
`define IOP_ROLE_ADDR   10'h140
`define IOP_BUS_ADDR    10'h144
`define IOP_PIN_ADDR    10'h148
`define IOP_ROWMAP_BASE 10'h180

// cell configuration word fields
`define IOP_F_MODE      1:0
`define IOP_F_REG_OUT   2
`define IOP_F_REG_EN    3
`define IOP_F_INVERT    4
`define IOP_F_OUT_SEL   9:5
`define IOP_F_CLK_SEL   13:10
`define IOP_F_CLR_SEL   17:14
`define IOP_F_OE_SEL    21:18
`define IOP_F_DRIVE_A   22
`define IOP_F_DRIVE_B   23
`define IOP_F_CLR_EN    24
`define IOP_CELL_MASK   32'h01ffffff

// source word fields: dedicated flag and channel index
`define IOP_F_SRC_DED   5
`define IOP_F_SRC_IDX   4:0

// selector value that keeps the output enable on
`define IOP_OE_ALWAYS   4'hf

// reset values
`define IOP_CELL_RST    32'h00000000
`define IOP_SRC_RST     6'h00
`define IOP_ROLE_RST    2'h0

// source row per line, 3 bits per variant, variant 0 lowest; 3'h7 means absent
`define IOP_ROWMAP_0  {3'h4, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0}
`define IOP_ROWMAP_1  {3'h1, 3'h1, 3'h2, 3'h2, 3'h1, 3'h1}
`define IOP_ROWMAP_2  {3'h5, 3'h5, 3'h1, 3'h1, 3'h0, 3'h0}
`define IOP_ROWMAP_3  {3'h2, 3'h2, 3'h3, 3'h2, 3'h1, 3'h1}
`define IOP_ROWMAP_4  {3'h0, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0}
`define IOP_ROWMAP_5  {3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1}
`define IOP_ROWMAP_6  {3'h1, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7}
`define IOP_ROWMAP_7  {3'h2, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7}
`define IOP_ROWMAP_8  {3'h3, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7}
`define IOP_ROWMAP_9  {3'h3, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7}
`define IOP_ROWMAP_10 {3'h4, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7}
`define IOP_ROWMAP_11 {3'h5, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7}

`endif

// >>> core/io_periph_pkg.sv
// types shared by the io periphery
`default_nettype none
package io_periph_pkg;
   typedef enum logic [1:0] {
      MODE_INPUT  = 2'h0,
      MODE_OUTPUT = 2'h1,
      MODE_BIDIR  = 2'h2
   } pin_mode_t;

   typedef enum logic [1:0] {
      KIND_CLOCK  = 2'h0,
      KIND_CLEAR  = 2'h1,
      KIND_ENABLE = 2'h2
   } ctrl_kind_t;
endpackage
`default_nettype wire
